// File: design/kms_defines.svh
/*
 * Register indices, field positions, reset values and timing figures of the
 * keypad matrix scanner.
 * Assumes a bus byte address of four times each register index.
 */
`ifndef KMS_DEFINES_SVH
`define KMS_DEFINES_SVH

// Register indices (word index, byte address = index * 4)
`define KMS_IDX_DRIVE      10'h0d1
`define KMS_IDX_SENSE      10'h0d2
`define KMS_IDX_TIMING     10'h0d3
`define KMS_IDX_CTRL       10'h0d4
`define KMS_IDX_SEQ_LO     10'h0d5
`define KMS_IDX_SEQ_HI     10'h0d6
`define KMS_IDX_DIM        10'h0d7
`define KMS_IDX_MCLK       10'h0d8

// Reset values
`define KMS_RST_DRIVE      5'h1f
`define KMS_RST_SENSE      6'h3f
`define KMS_RST_TIMING     8'h00
`define KMS_RST_SEQ_LO     8'h88
`define KMS_RST_SEQ_HI     8'h46
`define KMS_RST_DIM        8'h65
`define KMS_RST_MCLK       8'h00

// Control/status fields
`define KMS_CTRL_IRQ_EN    0
`define KMS_CTRL_DETECT    1
`define KMS_CTRL_SCAN_EN   2
// Master clock control field
`define KMS_MCLK_TICK_EN   6
// Scan timing fields
`define KMS_TIM_SCAN_LSB   0
`define KMS_TIM_DB_LSB     2

// Timing: 1 kHz tick from the 10 MHz clock
`define KMS_CLK_PERIOD_NS  100
`define KMS_TICK_PERIOD_NS 1000000
`define KMS_TICK_CYCLES    (`KMS_TICK_PERIOD_NS / `KMS_CLK_PERIOD_NS)
`define KMS_DB_STEP_MS     4

`endif

// File: design/kms_pkg.sv
/*
 * Types shared by the keypad matrix scanner.
 * Assumes nothing of its surroundings.
 */
package kms_pkg;
    typedef enum logic [2:0] {
        KMS_OFF,
        KMS_WAIT_PRESS,
        KMS_PRESS_DB,
        KMS_SCAN,
        KMS_WAIT_RELEASE,
        KMS_RELEASE_DB
    } kms_state_e;
endpackage

// File: design/kms_scanner.sv
/*
 * Keypad matrix scanner: 5 drive lines, 6 sense lines, Wishbone classic
 * register slave with 32-bit data, key-detect interrupt request.
 * Assumes sense pins are pulled up and asynchronous to clk; drive pins feed
 * the keypad columns directly. One 10 MHz clock, synchronous active-low reset.
 */
`include "kms_defines.svh"

module kms_scanner #(
    parameter int TICK_CYCLES = `KMS_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Keypad pins
    input  wire logic [5:0]  sense_n,
    output logic      [4:0]  drive_n,
    // Interrupt request
    output logic             key_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Low-active pattern with one drive line low; out-of-range leaves all high
    function automatic logic [4:0] drive_pattern(input logic [2:0] idx);
        logic [4:0] p;
        p = 5'h1f;
        if (idx < 3'h5) begin
            p[idx] = 1'b0;
        end
        return p;
    endfunction

    // Mask of the sense lines in use, count clamped to 1..6
    function automatic logic [5:0] sense_mask(input logic [2:0] n);
        logic [5:0] m;
        m = 6'h00;
        for (int i = 0; i < 6; i++) begin
            if (i < int'(n) || (i == 0)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // Line count clamped to 1..max
    function automatic logic [2:0] clamp_count(input logic [2:0] n, input logic [2:0] max);
        logic [2:0] c;
        c = n;
        if (n == 3'h0) begin
            c = 3'h1;
        end else if (n > max) begin
            c = max;
        end
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Registers and state

    kms_pkg::kms_state_e state_reg;
    kms_pkg::kms_state_e state_next;

    logic [4:0]  drive_reg;
    logic [5:0]  sense_reg;
    logic [7:0]  timing_reg;
    logic [7:0]  seq_lo_reg;
    logic [7:0]  seq_hi_reg;
    logic [7:0]  dim_reg;
    logic [7:0]  mclk_reg;
    logic        irq_en_reg;
    logic        detect_reg;
    logic        scan_en_reg;

    logic [5:0]  sense_s1_reg;
    logic [5:0]  sense_s2_reg;
    logic [5:0]  sense_s3_reg;
    logic [5:0]  sense_stable_reg;

    logic [13:0] div_reg;
    logic        tick_reg;
    logic [8:0]  tmr_reg;
    logic [2:0]  slot_reg;
    logic [2:0]  row_reg;
    logic [1:0]  hits_reg;
    logic [2:0]  hit_col_reg;
    logic [2:0]  hit_row_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    wire         bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire  [9:0]  bus_idx   = wb_adr_i[11:2];
    wire         bus_wr    = bus_req & wb_we_i & wb_sel_i[0];
    wire  [7:0]  wdat      = wb_dat_i[7:0];
    wire         wr_drive  = bus_wr & (bus_idx == `KMS_IDX_DRIVE);
    wire         wr_timing = bus_wr & (bus_idx == `KMS_IDX_TIMING);
    wire         wr_ctrl   = bus_wr & (bus_idx == `KMS_IDX_CTRL);
    wire         wr_seq_lo = bus_wr & (bus_idx == `KMS_IDX_SEQ_LO);
    wire         wr_seq_hi = bus_wr & (bus_idx == `KMS_IDX_SEQ_HI);
    wire         wr_dim    = bus_wr & (bus_idx == `KMS_IDX_DIM);
    wire         wr_mclk   = bus_wr & (bus_idx == `KMS_IDX_MCLK);

    wire  [7:0]  ctrl_view = {5'h00, scan_en_reg, detect_reg, irq_en_reg};
    wire  [7:0]  rd_byte   =
        (bus_idx == `KMS_IDX_DRIVE)  ? {3'h0, drive_reg} :
        (bus_idx == `KMS_IDX_SENSE)  ? {2'h0, sense_reg} :
        (bus_idx == `KMS_IDX_TIMING) ? timing_reg :
        (bus_idx == `KMS_IDX_CTRL)   ? ctrl_view :
        (bus_idx == `KMS_IDX_SEQ_LO) ? seq_lo_reg :
        (bus_idx == `KMS_IDX_SEQ_HI) ? seq_hi_reg :
        (bus_idx == `KMS_IDX_DIM)    ? dim_reg :
        (bus_idx == `KMS_IDX_MCLK)   ? mclk_reg : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Scan configuration

    wire  [15:0] seq_word   = {seq_hi_reg, seq_lo_reg};
    wire  [2:0]  n_cols     = clamp_count(dim_reg[2:0], 3'h5);
    wire  [2:0]  n_rows     = clamp_count(dim_reg[6:4], 3'h6);
    wire  [5:0]  row_mask   = sense_mask(n_rows);
    wire  [2:0]  cur_col    = seq_word[slot_reg * 3 +: 3];
    wire  [1:0]  sct_field  = timing_reg[`KMS_TIM_SCAN_LSB +: 2];
    wire  [5:0]  dbt_field  = timing_reg[`KMS_TIM_DB_LSB +: 6];
    wire  [8:0]  scan_ticks = (sct_field == 2'h0) ? 9'h004 : {7'h00, sct_field};
    wire  [8:0]  db_ticks   = {(dbt_field == 6'h00), dbt_field, 2'b00};
    wire  [8:0]  tmr_inc    = tmr_reg + 9'h001;
    wire         db_done    = tick_reg & (tmr_inc == db_ticks);
    wire         check_due  = tick_reg & (tmr_inc == scan_ticks);
    wire         any_low    = |(~sense_stable_reg & row_mask);
    wire         this_hit   = ~sense_stable_reg[row_reg];
    wire         last_row   = (row_reg == n_rows - 3'h1);
    wire         last_slot  = (slot_reg == n_cols - 3'h1);
    wire  [1:0]  hits_new   = (this_hit && hits_reg != 2'h2) ? hits_reg + 2'h1 : hits_reg;
    wire         scan_end   = (state_reg == kms_pkg::KMS_SCAN) & check_due
                              & last_row & last_slot;
    wire         key_valid  = scan_end & (hits_new == 2'h1);
    wire  [2:0]  valid_col  = this_hit ? cur_col : hit_col_reg;
    wire  [2:0]  valid_row  = this_hit ? row_reg : hit_row_reg;
    wire  [5:0]  valid_pat  = ~(6'h01 << valid_row);

    ////////////////////////////////////////////////////////////////////////////
    // Drive pin value

    wire  [4:0]  drive_next =
        (!scan_en_reg || state_reg == kms_pkg::KMS_OFF) ? drive_reg :
        (state_reg == kms_pkg::KMS_SCAN) ? drive_pattern(cur_col) : 5'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Scanner state machine

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            kms_pkg::KMS_OFF: begin
                if (scan_en_reg) begin
                    state_next = kms_pkg::KMS_WAIT_PRESS;
                end
            end
            kms_pkg::KMS_WAIT_PRESS: begin
                if (any_low) begin
                    state_next = kms_pkg::KMS_PRESS_DB;
                end
            end
            kms_pkg::KMS_PRESS_DB: begin
                if (db_done) begin
                    state_next = any_low ? kms_pkg::KMS_SCAN
                                         : kms_pkg::KMS_WAIT_PRESS;
                end
            end
            kms_pkg::KMS_SCAN: begin
                if (scan_end) begin
                    state_next = kms_pkg::KMS_WAIT_RELEASE;
                end
            end
            kms_pkg::KMS_WAIT_RELEASE: begin
                if (!any_low) begin
                    state_next = kms_pkg::KMS_RELEASE_DB;
                end
            end
            kms_pkg::KMS_RELEASE_DB: begin
                if (db_done && !any_low) begin
                    state_next = kms_pkg::KMS_WAIT_PRESS;
                end
            end
            default: begin
                state_next = kms_pkg::KMS_OFF;
            end
        endcase
        if (!scan_en_reg) begin
            state_next = kms_pkg::KMS_OFF;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg <= kms_pkg::KMS_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sense pin synchroniser, stable once second and third stages agree

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sense_s1_reg     <= 6'h3f;
            sense_s2_reg     <= 6'h3f;
            sense_s3_reg     <= 6'h3f;
            sense_stable_reg <= 6'h3f;
        end else begin
            sense_s1_reg <= sense_n;
            sense_s2_reg <= sense_s1_reg;
            sense_s3_reg <= sense_s2_reg;
            if (sense_s2_reg == sense_s3_reg) begin
                sense_stable_reg <= sense_s3_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // 1 kHz tick, gated by the tick enable

    always_ff @(posedge clk) begin
        if (!resetn) begin
            div_reg  <= 14'h0000;
            tick_reg <= 1'b0;
        end else if (!mclk_reg[`KMS_MCLK_TICK_EN]) begin
            div_reg  <= 14'h0000;
            tick_reg <= 1'b0;
        end else if (div_reg == 14'(TICK_CYCLES - 1)) begin
            div_reg  <= 14'h0000;
            tick_reg <= 1'b1;
        end else begin
            div_reg  <= div_reg + 14'h0001;
            tick_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Debounce and scan interval timer

    always_ff @(posedge clk) begin
        if (!resetn || state_next != state_reg) begin
            tmr_reg <= 9'h000;
        end else if (db_done && state_reg != kms_pkg::KMS_SCAN) begin
            tmr_reg <= 9'h000;
        end else if (check_due && state_reg == kms_pkg::KMS_SCAN) begin
            tmr_reg <= 9'h000;
        end else if (tick_reg) begin
            tmr_reg <= tmr_inc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Scan position and hit collection

    always_ff @(posedge clk) begin
        if (!resetn || state_reg != kms_pkg::KMS_SCAN) begin
            slot_reg    <= 3'h0;
            row_reg     <= 3'h0;
            hits_reg    <= 2'h0;
            hit_col_reg <= 3'h0;
            hit_row_reg <= 3'h0;
        end else if (check_due) begin
            hits_reg <= hits_new;
            if (this_hit) begin
                hit_col_reg <= cur_col;
                hit_row_reg <= row_reg;
            end
            if (last_row) begin
                row_reg  <= 3'h0;
                slot_reg <= slot_reg + 3'h1;
            end else begin
                row_reg <= row_reg + 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software registers

    always_ff @(posedge clk) begin
        if (!resetn) begin
            timing_reg  <= `KMS_RST_TIMING;
            seq_lo_reg  <= `KMS_RST_SEQ_LO;
            seq_hi_reg  <= `KMS_RST_SEQ_HI;
            dim_reg     <= `KMS_RST_DIM;
            mclk_reg    <= `KMS_RST_MCLK;
            irq_en_reg  <= 1'b0;
            scan_en_reg <= 1'b0;
        end else begin
            if (wr_timing) begin
                timing_reg <= wdat;
            end
            if (wr_seq_lo) begin
                seq_lo_reg <= wdat;
            end
            if (wr_seq_hi) begin
                seq_hi_reg <= wdat;
            end
            if (wr_dim) begin
                dim_reg <= wdat;
            end
            if (wr_mclk) begin
                mclk_reg <= wdat;
            end
            if (wr_ctrl) begin
                irq_en_reg  <= wdat[`KMS_CTRL_IRQ_EN];
                scan_en_reg <= wdat[`KMS_CTRL_SCAN_EN];
            end
        end
    end

    // Result registers: bypass writes drive and samples sense live
    always_ff @(posedge clk) begin
        if (!resetn) begin
            drive_reg <= `KMS_RST_DRIVE;
            sense_reg <= `KMS_RST_SENSE;
        end else if (key_valid) begin
            drive_reg <= drive_pattern(valid_col);
            sense_reg <= valid_pat;
        end else begin
            if (wr_drive) begin
                drive_reg <= wdat[4:0];
            end
            if (!scan_en_reg) begin
                sense_reg <= sense_stable_reg;
            end
        end
    end

    // Detect flag: a new key wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            detect_reg <= 1'b0;
        end else if (key_valid) begin
            detect_reg <= 1'b1;
        end else if (wr_ctrl && !wdat[`KMS_CTRL_DETECT]) begin
            detect_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            drive_n  <= `KMS_RST_DRIVE;
            key_irq  <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            drive_n  <= drive_next;
            key_irq  <= detect_reg & irq_en_reg;
        end
    end

endmodule

// File: sim/kms_scanner_assertions.sv
/*
 * Port-level assertions of the keypad matrix scanner.
 * Assumes only the scanner's top-level ports; attached by bind below.
 */
`include "kms_defines.svh"
module kms_scanner_assertions #(
    parameter int TICK_CYCLES = `KMS_TICK_CYCLES
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        resetn,
    // Register bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Keypad pins and request
    input wire logic [5:0]  sense_n,
    input wire logic [4:0]  drive_n,
    input wire logic        key_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    ////////////////////////////////////////////////////////////////////////////
    logic       take;
    logic       wr_en;
    logic [9:0] idx;
    logic       irq_en_q;
    logic       scan_q;
    logic       tick_q;
    logic       rd_drv_q;
    logic [3:0] scan_cnt;
    logic [3:0] frz_cnt;
    assign take  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_en = take && wb_we_i && wb_sel_i[0];
    assign idx   = wb_adr_i[11:2];
    // Shadow copies of the control bits and settle counters
    always_ff @(posedge clk) begin
        if (!resetn) begin
            irq_en_q <= 1'b0;
            scan_q   <= 1'b0;
            tick_q   <= 1'b0;
            rd_drv_q <= 1'b0;
            scan_cnt <= 4'h0;
            frz_cnt  <= 4'h0;
        end else begin
            if (wr_en && idx == `KMS_IDX_CTRL) begin
                irq_en_q <= wb_dat_i[`KMS_CTRL_IRQ_EN];
                scan_q   <= wb_dat_i[`KMS_CTRL_SCAN_EN];
            end
            if (wr_en && idx == `KMS_IDX_MCLK) tick_q <= wb_dat_i[`KMS_MCLK_TICK_EN];
            rd_drv_q <= take && !wb_we_i && idx == `KMS_IDX_DRIVE;
            scan_cnt <= !scan_q ? 4'h0 : (scan_cnt == 4'hf) ? scan_cnt : scan_cnt + 4'h1;
            frz_cnt  <= !(scan_q && !tick_q) ? 4'h0 : (frz_cnt == 4'hf) ? frz_cnt
                        : frz_cnt + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    property p_rst_drive;
        @(posedge clk) disable iff (!resetn)
        $rose(resetn) |-> drive_n == 5'h1f && !key_irq;
    endproperty
    a_rst_drive: assert property (p_rst_drive)
        else $error("drive pins or request wrong after reset");
    property p_idle_low;
        @(posedge clk) disable iff (!resetn)
        wr_en && idx == `KMS_IDX_CTRL && wb_dat_i[2] && !scan_q && sense_n == 6'h3f
            |-> ##[1:3] drive_n == 5'h00;
    endproperty
    a_idle_low: assert property (p_idle_low)
        else $error("drive lines not all low once scanning starts");
    property p_one_low;
        @(posedge clk) disable iff (!resetn)
        scan_q && scan_cnt >= 4'h3 |-> drive_n == 5'h00 || $countones(~drive_n) <= 1;
    endproperty
    a_one_low: assert property (p_one_low)
        else $error("more than one drive line low while scanning");
    property p_freeze;
        @(posedge clk) disable iff (!resetn)
        frz_cnt >= 4'h4 |-> $stable(drive_n);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("drive lines moved with the tick stopped");
    property p_manual;
        @(posedge clk) disable iff (!resetn)
        wr_en && idx == `KMS_IDX_DRIVE && !scan_q |-> ##2 drive_n == $past(wb_dat_i[4:0], 2);
    endproperty
    a_manual: assert property (p_manual)
        else $error("drive pins do not follow the written pattern");
    property p_rd_drive;
        @(posedge clk) disable iff (!resetn)
        wb_ack_o && rd_drv_q && !scan_q && !$past(scan_q) |-> wb_dat_o[4:0] == drive_n;
    endproperty
    a_rd_drive: assert property (p_rd_drive)
        else $error("drive register and drive pins differ");
    property p_irq_en;
        @(posedge clk) disable iff (!resetn)
        key_irq |-> $past(irq_en_q);
    endproperty
    a_irq_en: assert property (p_irq_en)
        else $error("request raised while disabled");
    property p_irq_off;
        @(posedge clk) disable iff (!resetn)
        wr_en && idx == `KMS_IDX_CTRL && !wb_dat_i[0] |-> ##2 !key_irq [*2];
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("request stays after disable");
    property p_dat_width;
        @(posedge clk) disable iff (!resetn)
        wb_ack_o |-> wb_dat_o[31:8] == 24'h0;
    endproperty
    a_dat_width: assert property (p_dat_width)
        else $error("read data upper bits not zero");
endmodule

bind kms_scanner kms_scanner_assertions #(.TICK_CYCLES(TICK_CYCLES)) chk (
    .clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sense_n(sense_n), .drive_n(drive_n),
    .key_irq(key_irq));

// File: sim/kms_keypad_model.sv
/*
 * Switch matrix model: 5 drive lines by 6 pulled-up sense lines.
 * Assumes the bench sets key bits, bit 6*column+row closed.
 */
module kms_keypad_model (
    // Switch states
    input  wire logic [29:0] keys,
    // Matrix pins
    input  wire logic [4:0]  drive_n,
    output logic      [5:0]  sense_n
);
    timeunit 1ns;
    timeprecision 1ns;
    always_comb begin
        sense_n = 6'h3f;
        for (int c = 0; c < 5; c++)
            for (int r = 0; r < 6; r++)
                if (keys[6 * c + r] && !drive_n[c]) sense_n[r] = 1'b0;
    end
endmodule

// File: sim/kms_scanner_tb.sv
/*
 * Self-checking bench of the keypad matrix scanner.
 * Assumes the design, keypad model and checker are compiled first.
 */
`include "kms_defines.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
$display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module kms_scanner_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TK = 10;
    localparam logic [7:0] RST [9] = '{8'h1f, 8'h3f, 8'h00, 8'h00, 8'h88, 8'h46, 8'h65,
                                       8'h00, 8'h00};
    logic        clk, resetn, cyc, stb, we, ack, key_irq, rev, two, miss;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat;
    logic [5:0]  sense_n, lr;
    logic [4:0]  drive_n, lc;
    logic [29:0] keys;
    logic [7:0]  q;
    int          n_errors, compares, n, k1, k2, c, r;
    kms_scanner #(.TICK_CYCLES(TK)) dut (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .sense_n(sense_n), .drive_n(drive_n),
        .key_irq(key_irq));
    kms_keypad_model keypad (.keys(keys), .drive_n(drive_n), .sense_n(sense_n));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [4:0] col_pat(input int k);
        return 5'h1f & ~(5'h01 << k);
    endfunction
    function automatic logic [5:0] row_pat(input int k);
        return 6'h3f & ~(6'h01 << k);
    endfunction
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h0, d};
        sel <= 4'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin n_errors++; final_report(); end
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wait_irq(input logic lvl, input int lim);
        n = 0;
        while (key_irq !== lvl && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (key_irq !== lvl) begin n_errors++; final_report(); end
    endtask
    task automatic wait_scan();
        n = 0;
        while (drive_n === 5'h00 && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (drive_n === 5'h00) begin n_errors++; final_report(); end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        resetn = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 12'h000;
        sel = 4'h0;
        wdat = 32'h0;
        keys = 30'h0;
        n_errors = 0;
        compares = 0;
        void'($urandom(79));
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            bus(1'b0, `KMS_IDX_DRIVE + 10'(i), 8'h00);
            `CHK(q, RST[i])
        end
        `CHK(drive_n, 5'h1f)
        $display("Test reset values done");
        for (int t = 0; t < 4; t++) begin
            c = $urandom % 5;
            r = $urandom % 6;
            keys <= 30'h1 << (6 * c + r);
            for (int k = 0; k < 5; k++) begin
                bus(1'b1, `KMS_IDX_DRIVE, {3'h0, col_pat(k)});
                repeat (6) @(posedge clk);
                `CHK(drive_n, col_pat(k))
                bus(1'b0, `KMS_IDX_SENSE, 8'h00);
                `CHK(q[5:0], (k == c) ? row_pat(r) : 6'h3f)
            end
        end
        keys <= 30'h0;
        $display("Test manual scanning done");
        bus(1'b1, `KMS_IDX_TIMING, 8'h05);
        keys <= 30'h1;
        bus(1'b1, `KMS_IDX_CTRL, 8'h05);
        repeat (60) @(posedge clk);
        `CHK(drive_n, 5'h00)
        keys <= 30'h0;
        bus(1'b1, `KMS_IDX_MCLK, 8'h40);
        repeat (8 * TK) @(posedge clk);
        `CHK(drive_n, 5'h00)
        $display("Test tick gate done");
        for (int t = 0; t < 8; t++) begin
            rev = t[0];
            two = (t % 4 == 3);
            miss = (t == 6);
            k1 = miss ? 24 : $urandom % 30;
            k2 = (k1 + 1 + $urandom % 29) % 30;
            bus(1'b1, `KMS_IDX_CTRL, (t == 2) ? 8'h04 : 8'h05);
            bus(1'b1, `KMS_IDX_SEQ_LO, rev ? 8'h9c : 8'h88);
            bus(1'b1, `KMS_IDX_SEQ_HI, rev ? 8'h02 : 8'h46);
            bus(1'b1, `KMS_IDX_TIMING, {6'h01, t[1:0]});
            bus(1'b1, `KMS_IDX_DIM, miss ? 8'h12 : 8'h65);
            keys <= (30'h1 << k1) | (30'(two) << k2);
            wait_scan();
            `CHK(n >= 3 * TK, 1'b1)
            `CHK(drive_n, col_pat(rev ? 4 : 0))
            if (two || miss) begin
                repeat (2000) @(posedge clk);
                `CHK(key_irq, 1'b0)
            end else begin
                if (t == 2) begin
                    repeat (1500) @(posedge clk);
                    `CHK(key_irq, 1'b0)
                    bus(1'b1, `KMS_IDX_CTRL, 8'h07);
                end
                wait_irq(1'b1, 2000);
                lc = col_pat(k1 / 6);
                lr = row_pat(k1 % 6);
                bus(1'b0, `KMS_IDX_CTRL, 8'h00);
                `CHK(q, 8'h07)
                bus(1'b1, `KMS_IDX_CTRL, 8'h05);
                wait_irq(1'b0, 4);
            end
            bus(1'b0, `KMS_IDX_DRIVE, 8'h00);
            `CHK(q[4:0], lc)
            bus(1'b0, `KMS_IDX_SENSE, 8'h00);
            `CHK(q[5:0], lr)
            keys <= 30'h0;
            if (t == 1) begin
                repeat (2 * TK) @(posedge clk);
                keys <= 30'h1 << k1;
                repeat (60 * TK) @(posedge clk);
                `CHK(key_irq, 1'b0)
                keys <= 30'h0;
            end
            repeat (8 * TK) @(posedge clk);
            $display("Test scan %0d done", t);
        end
        keys <= 30'h1 << ($urandom % 30);
        wait_scan();
        bus(1'b1, `KMS_IDX_CTRL, 8'h00);
        repeat (3) @(posedge clk);
        `CHK(drive_n, lc)
        bus(1'b0, `KMS_IDX_DRIVE, 8'h00);
        `CHK(q[4:0], lc)
        keys <= 30'h0;
        $display("Test scan stop done");
        final_report();
    end
endmodule
